/* File: rtl/ialu_params.svh */
// Notes on behaviour
// - add_const_wrap: sign-extend 16-bit constant, add to A mod 2^32, no trap.
// - add_wrap decoded from opcode 000000, function 100001, bits 10..6 zero.
// - add_wrap writes 32-bit sum of both sources to destination, never traps.
// - pair_byte_align merges float_src_a, float_src_b halves for any nonzero count; zero copies a.
// - count 4: big-endian a low, b high; little-endian b low, a high.
// - pair_byte_align is a plain move raising no floating-point exceptions.
// - pair_byte_align traps unusable coprocessor or reserved instruction when unsupported.
// - register AND from opcode 000000, function 100100, writes A and B, no trap.
// - and_const zero-extends 16-bit constant, ANDs with A, writes register B.
// - unconditional branch runs as equal_test_jump r0,r0 and is always taken.
// - target is delay-slot address plus sign-extended offset shifted left two.
// - call_relative runs as nonneg_call on r0 and is always taken.
// - call_relative writes branch address plus 8 into register 31.
`ifndef IALU_PARAMS_SVH
`define IALU_PARAMS_SVH
`define IALU_OP_SPECIAL   6'h00
`define IALU_OP_REGIMM    6'h01
`define IALU_OP_EQ_JUMP   6'h04
`define IALU_OP_ADD_CONST 6'h09
`define IALU_OP_AND_CONST 6'h0c
`define IALU_OP_COP1X     6'h13
`define IALU_FN_ADD_WRAP  6'h21
`define IALU_FN_AND       6'h24
`define IALU_FN_ALIGN     6'h1e
`define IALU_RI_NONNEG    5'h11
`define IALU_ZERO_REG     5'h00
`define IALU_LINK_REG     5'h1f
`define IALU_LINK_OFS     32'h0000_0008
`define IALU_SLOT_OFS     32'h0000_0004
`define IALU_ALIGN_HALF   3'h4
`define IALU_ALIGN_NONE   3'h0
`endif

/* File: rtl/ialu_pkg.sv */
package ialu_pkg;
   typedef struct packed {
      logic        valid;
      logic [31:0] instr;
      logic [31:0] pc;
      logic [31:0] src_a;
      logic [31:0] src_b;
      logic [63:0] float_src_a;
      logic [63:0] float_src_b;
   } ialu_issue_type;

   typedef struct packed {
      logic        valid;
      logic        gpr_we;
      logic [4:0]  gpr_idx;
      logic [31:0] gpr_data;
      logic        fpr_we;
      logic [4:0]  fpr_idx;
      logic [63:0] fpr_data;
      logic        cop_unusable;
      logic        reserved_instr;
   } ialu_result_type;

   typedef struct packed {
      logic        valid;
      logic [31:0] target;
   } ialu_redirect_type;

   typedef enum logic [0:0] {IALU_RUN, IALU_SLOT} ialu_state_type;
endpackage

/* File: rtl/ialu_slice.sv */
`timescale 1ns/10ps
`include "ialu_params.svh"
module ialu_slice (
   input  wire logic                        ref_clk_i,
   input  wire logic                        nrst_i,
   input  wire ialu_pkg::ialu_issue_type    issue_i,
   input  wire logic                        cop1_enable_i,
   input  wire logic                        pair_support_i,
   input  wire logic                        big_endian_i,
   output      ialu_pkg::ialu_result_type   result_o,
   output      ialu_pkg::ialu_redirect_type redirect_o
);
   ialu_pkg::ialu_result_type   res_q,   res_d;
   ialu_pkg::ialu_redirect_type redir_q, redir_d;
   ialu_pkg::ialu_state_type    state_q, state_d;
   logic [31:0]                 tgt_q,   tgt_d;

   logic [5:0]  opc, fn;
   logic [4:0]  ra, rb, rd, sh, fdst;
   logic [15:0] imm;
   logic [31:0] sx_imm, zx_imm, br_ofs;
   logic [2:0]  cnt;
   logic        is_branch;

   assign opc    = issue_i.instr[31:26];
   assign ra     = issue_i.instr[25:21];
   assign rb     = issue_i.instr[20:16];
   assign rd     = issue_i.instr[15:11];
   assign sh     = issue_i.instr[10:6];
   assign fn     = issue_i.instr[5:0];
   assign fdst   = issue_i.instr[10:6];
   assign imm    = issue_i.instr[15:0];
   assign sx_imm = {{16{imm[15]}}, imm};
   assign zx_imm = {16'h0000, imm};
   assign br_ofs = {{14{imm[15]}}, imm, 2'b00};
   assign cnt    = issue_i.src_a[2:0];
   // only the r0 forms are always taken
   assign is_branch = issue_i.valid && (ra == `IALU_ZERO_REG) &&
                      ((opc == `IALU_OP_EQ_JUMP && rb == `IALU_ZERO_REG) ||
                       (opc == `IALU_OP_REGIMM && rb == `IALU_RI_NONNEG));

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      res_d        = '0;
      res_d.valid  = issue_i.valid;
      redir_d      = '0;
      state_d      = state_q;
      tgt_d        = tgt_q;
      if (issue_i.valid) begin
         case (opc)
            `IALU_OP_ADD_CONST: begin
               res_d.gpr_we   = 1'b1;
               res_d.gpr_idx  = rb;
               res_d.gpr_data = issue_i.src_a + sx_imm;
            end
            `IALU_OP_AND_CONST: begin
               res_d.gpr_we   = 1'b1;
               res_d.gpr_idx  = rb;
               res_d.gpr_data = issue_i.src_a & zx_imm;
            end
            `IALU_OP_SPECIAL: begin
               if (fn == `IALU_FN_ADD_WRAP && sh == `IALU_ZERO_REG) begin
                  res_d.gpr_we   = 1'b1;
                  res_d.gpr_idx  = rd;
                  res_d.gpr_data = issue_i.src_a + issue_i.src_b;
               end else if (fn == `IALU_FN_AND && sh == `IALU_ZERO_REG) begin
                  res_d.gpr_we   = 1'b1;
                  res_d.gpr_idx  = rd;
                  res_d.gpr_data = issue_i.src_a & issue_i.src_b;
               end
            end
            `IALU_OP_COP1X: begin
               if (fn == `IALU_FN_ALIGN) begin
                  if (!cop1_enable_i) begin
                     res_d.cop_unusable = 1'b1;
                  end else if (!pair_support_i) begin
                     res_d.reserved_instr = 1'b1;
                  end else begin
                     // plain move, no fp flags produced
                     res_d.fpr_we  = 1'b1;
                     res_d.fpr_idx = fdst;
                     if (cnt == `IALU_ALIGN_NONE) begin
                        res_d.fpr_data = issue_i.float_src_a;
                     end else if (big_endian_i) begin
                        res_d.fpr_data = {issue_i.float_src_a[31:0],
                                          issue_i.float_src_b[63:32]};
                     end else begin
                        res_d.fpr_data = {issue_i.float_src_b[31:0],
                                          issue_i.float_src_a[63:32]};
                     end
                  end
               end
            end
            `IALU_OP_REGIMM: begin
               if (is_branch) begin
                  res_d.gpr_we   = 1'b1;
                  res_d.gpr_idx  = `IALU_LINK_REG;
                  res_d.gpr_data = issue_i.pc + `IALU_LINK_OFS;
               end
            end
            default: begin
            end
         endcase
      end
      case (state_q)
         ialu_pkg::IALU_RUN: begin
            if (is_branch) begin
               tgt_d   = issue_i.pc + `IALU_SLOT_OFS + br_ofs;
               state_d = ialu_pkg::IALU_SLOT;
            end
         end
         ialu_pkg::IALU_SLOT: begin
            if (issue_i.valid) begin
               redir_d.valid  = 1'b1;
               redir_d.target = tgt_q;
               state_d        = ialu_pkg::IALU_RUN;
            end
         end
         default: state_d = ialu_pkg::IALU_RUN;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         res_q   <= '0;
         redir_q <= '0;
         state_q <= ialu_pkg::IALU_RUN;
         tgt_q   <= 32'h0000_0000;
      end else begin
         res_q   <= res_d;
         redir_q <= redir_d;
         state_q <= state_d;
         tgt_q   <= tgt_d;
      end
   end

   assign result_o   = res_q;
   assign redirect_o = redir_q;

   ////////////////////////////////////////////////////////////////////////
   add_const_sum_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      issue_i.valid && opc == `IALU_OP_ADD_CONST |=> result_o.gpr_we &&
      result_o.gpr_data == $past(issue_i.src_a) + {{16{$past(imm[15])}}, $past(imm)})
      else $error("add_const_wrap sum wrong");
   add_wrap_sum_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      issue_i.valid && opc == `IALU_OP_SPECIAL && fn == `IALU_FN_ADD_WRAP &&
      sh == `IALU_ZERO_REG
      |=> result_o.gpr_idx == $past(rd) &&
          result_o.gpr_data == $past(issue_i.src_a) + $past(issue_i.src_b))
      else $error("add_wrap sum wrong");
   add_no_trap_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      issue_i.valid && (opc == `IALU_OP_SPECIAL || opc == `IALU_OP_ADD_CONST)
      |=> !result_o.cop_unusable && !result_o.reserved_instr)
      else $error("wrapping add raised a trap");
   add_wrap_shift_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      issue_i.valid && opc == `IALU_OP_SPECIAL && sh != `IALU_ZERO_REG |=> !result_o.gpr_we)
      else $error("nonzero shift field accepted");
   and_reg_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      issue_i.valid && opc == `IALU_OP_SPECIAL && fn == `IALU_FN_AND && sh == `IALU_ZERO_REG
      |=> result_o.gpr_data == ($past(issue_i.src_a) & $past(issue_i.src_b)))
      else $error("register and wrong");
   and_const_zext_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      issue_i.valid && opc == `IALU_OP_AND_CONST |=> result_o.gpr_data[31:16] == 16'h0000 &&
      result_o.gpr_idx == $past(rb))
      else $error("and_const not zero extended");
   and_const_val_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      issue_i.valid && opc == `IALU_OP_AND_CONST
      |=> result_o.gpr_we &&
          result_o.gpr_data == ($past(issue_i.src_a) & {16'h0000, $past(imm)}))
      else $error("and_const value wrong");
   result_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      1'b1 |=> result_o.valid == $past(issue_i.valid))
      else $error("result valid not one per issue");
   align_swap_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      issue_i.valid && opc == `IALU_OP_COP1X && fn == `IALU_FN_ALIGN && cop1_enable_i &&
      pair_support_i && cnt == `IALU_ALIGN_HALF
      |=> result_o.fpr_we && result_o.fpr_data == ($past(big_endian_i) ?
          {$past(issue_i.float_src_a[31:0]), $past(issue_i.float_src_b[63:32])} :
          {$past(issue_i.float_src_b[31:0]), $past(issue_i.float_src_a[63:32])}))
      else $error("align count four wrong");
   align_no_exc_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      issue_i.valid && opc == `IALU_OP_COP1X && fn == `IALU_FN_ALIGN && cop1_enable_i &&
      pair_support_i |=> !result_o.cop_unusable && !result_o.reserved_instr)
      else $error("align move raised a trap");
   align_reserved_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      issue_i.valid && opc == `IALU_OP_COP1X && fn == `IALU_FN_ALIGN && cop1_enable_i &&
      !pair_support_i |=> result_o.reserved_instr && !result_o.fpr_we)
      else $error("unsupported align not trapped");
   jump_no_write_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      is_branch && opc == `IALU_OP_EQ_JUMP |=> result_o.valid && !result_o.gpr_we)
      else $error("plain branch wrote a register");
   call_link_we_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      is_branch && opc == `IALU_OP_REGIMM |=> result_o.gpr_we)
      else $error("call did not link");
   align_zero_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      ##1 $past(issue_i.valid) && result_o.fpr_we && $past(cnt) == 3'h0
      |-> result_o.fpr_data == $past(issue_i.float_src_a))
      else $error("align count zero not copy");
   align_trap_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      issue_i.valid && opc == `IALU_OP_COP1X && fn == `IALU_FN_ALIGN && !cop1_enable_i
      |=> result_o.cop_unusable && !result_o.fpr_we)
      else $error("disabled coprocessor not trapped");
   link_addr_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      is_branch && opc == `IALU_OP_REGIMM |=> result_o.gpr_idx == `IALU_LINK_REG &&
      result_o.gpr_data == $past(issue_i.pc) + `IALU_LINK_OFS)
      else $error("link address wrong");
   slot_redir_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      is_branch && state_q == ialu_pkg::IALU_RUN |=> !redirect_o.valid)
      else $error("redirect before delay slot");
   branch_target_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      is_branch && state_q == ialu_pkg::IALU_RUN ##1 issue_i.valid
      |=> redirect_o.valid &&
          redirect_o.target == $past(issue_i.pc, 2) + `IALU_SLOT_OFS + $past(br_ofs, 2))
      else $error("branch target wrong");
endmodule

/* File: dv/ialu_issue_model.sv */
`timescale 1ns/10ps
module ialu_issue_model (
   input  wire logic                     ref_clk_i,
   output      ialu_pkg::ialu_issue_type issue_o
);
   initial issue_o = '0;
   // callers keep delay slots free of branches, link source off r31
   task send(input logic [31:0] ins, pc, a, b, input logic [63:0] fa, fb);
      @(posedge ref_clk_i);
      issue_o <= '{1'b1, ins, pc, a, b, fa, fb};
   endtask
   // released bus shows the previous cycle's payload inverted; a second idle in a row restores the stale copy
   task idle();
      @(posedge ref_clk_i);
      issue_o <= {1'b0, ~issue_o[$bits(issue_o)-2:0]};
   endtask
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
   logic                        ref_clk_i;
   logic                        nrst_i;
   logic                        cop1_enable_i;
   logic                        pair_support_i;
   logic                        big_endian_i;
   ialu_pkg::ialu_issue_type    issue;
   ialu_pkg::ialu_result_type   result;
   ialu_pkg::ialu_redirect_type redirect;
   ialu_pkg::ialu_result_type   exp_q[$];
   ialu_pkg::ialu_result_type   ex, sx;
   logic [31:0]                 tgt_q[$];
   integer                      miscompares = 0;
   integer                      tests_run = 0;
   integer                      seed = 32'h3ad456ad;
   integer                      i;
   logic [31:0]                 a, b, p;
   logic [15:0]                 k;
   logic [63:0]                 fa, fb, exp_f;

   ialu_slice u_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .issue_i(issue),
      .cop1_enable_i(cop1_enable_i), .pair_support_i(pair_support_i),
      .big_endian_i(big_endian_i), .result_o(result), .redirect_o(redirect));
   ialu_issue_model u_pipe (.ref_clk_i(ref_clk_i), .issue_o(issue));

   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   task check(input string name, input logic [127:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task results();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   function automatic ialu_pkg::ialu_result_type mk(input logic gw, input logic [4:0] gi,
      input logic [31:0] gd, input logic fw, input logic [4:0] fi, input logic [63:0] fv,
      input logic cu, input logic ri);
      mk = '{1'b1, gw, gi, gd, fw, fi, fv, cu, ri};
   endfunction

   task op(input logic [31:0] ins, input ialu_pkg::ialu_result_type e);
      exp_q.push_back(e);
      u_pipe.send(ins, p, a, b, fa, fb);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   always @(negedge ref_clk_i) begin
      if (result.valid === 1'b1) begin
         if (exp_q.size() == 0) check("extra result", 128'd1, 128'd0);
         else begin
            ex = exp_q.pop_front();
            sx = result;
            if (ex.gpr_we !== 1'b1) {ex.gpr_idx, ex.gpr_data} = '0;
            if (ex.fpr_we !== 1'b1) {ex.fpr_idx, ex.fpr_data} = '0;
            check("result", 128'(sx), 128'(ex));
         end
      end
      if (redirect.valid === 1'b1) begin
         check("slot before redirect", 128'(result.valid), 128'd1);
         if (tgt_q.size() == 0) check("extra redirect", 128'd1, 128'd0);
         else check("target", 128'(redirect.target), 128'(tgt_q.pop_front()));
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {nrst_i, a, b, p, fa, fb} = '0;
      {cop1_enable_i, pair_support_i, big_endian_i} = 3'b111;
      repeat (2) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      for (i = 0; i < 6; i++) begin
         a = (i == 1) ? 32'hffff_ffff : $random(seed);
         k = (i == 0) ? 16'h8000 : $random(seed);
         op({6'h09, 5'd3, 5'(i + 1), k}, mk(1, 5'(i + 1), a + {{16{k[15]}}, k}, 0, 0, 0, 0, 0));
      end
      for (i = 0; i < 4; i++) begin
         {a, b} = (i == 0) ? {32'h7fff_ffff, 32'h0000_0001} : {$random(seed), $random(seed)};
         k = $random(seed);
         op({6'h00, 5'd1, 5'd2, 5'(i + 4), 5'd0, 6'h21}, mk(1, 5'(i + 4), a + b, 0, 0, 0, 0, 0));
         op({6'h00, 5'd1, 5'd2, 5'(i + 8), 5'd0, 6'h24}, mk(1, 5'(i + 8), a & b, 0, 0, 0, 0, 0));
         op({6'h0c, 5'd1, 5'(i + 12), k}, mk(1, 5'(i + 12), a & {16'h0000, k}, 0, 0, 0, 0, 0));
         op({6'h00, 5'd1, 5'd2, 5'(i + 4), 5'(i + 1), 6'h21}, mk(0, 0, 0, 0, 0, 0, 0, 0));
      end
      $display("test integer ops done");
      for (i = 0; i < 8; i++) begin
         a = ($random(seed) & 32'hffff_fff8) | (i[1] ? 32'h0000_0004 : 32'h0000_0000);
         {fa, fb} = {$random(seed), $random(seed), $random(seed), $random(seed)};
         exp_f = !i[1] ? fa : (i[0] ? {fa[31:0], fb[63:32]} : {fb[31:0], fa[63:32]});
         // wide register mode assumed throughout
         op({6'h13, 5'd2, 5'd4, 5'd5, 5'(i + 16), 6'h1e},
            mk(0, 0, 0, i < 6, 5'(i + 16), exp_f, i == 6, i == 7));
         big_endian_i <= i[0];
         cop1_enable_i <= (i != 6);
         pair_support_i <= (i != 7);
      end
      u_pipe.idle();
      {cop1_enable_i, pair_support_i} <= 2'b11;
      $display("test pair align done");
      for (i = 0; i < 2; i++) begin
         p = $random(seed) & 32'hffff_fffc;
         k = i ? 16'h8003 : 16'h0010;
         tgt_q.push_back(p + 32'h0000_0004 + {{14{k[15]}}, k, 2'b00});
         op(i ? {6'h01, 5'd0, 5'h11, k} : {6'h04, 5'd0, 5'd0, k}, mk(i, 31, p + 8, 0, 0, 0, 0, 0));
         if (i == 1) u_pipe.idle();
         p = p + 32'h0000_0004;
         op({6'h00, 5'd1, 5'd2, 5'd9, 5'd0, 6'h21}, mk(1, 9, a + b, 0, 0, 0, 0, 0));
      end
      u_pipe.idle();
      repeat (4) @(posedge ref_clk_i);
      check("pending", 128'(exp_q.size() + tgt_q.size()), 128'd0);
      $display("test branches done");
      results();
   end

   initial begin
      #20000;
      miscompares++;
      results();
   end
endmodule
